// ---- dv/fetch_model.sv ----
// Purpose: Fetch stage model that hands opcode bytes to the decoder
// Assumes: Bytes change only at the falling edge
// Notes: Context travels with every byte of a form
`timescale 1ns/100ps
`default_nettype none
module fetch_model (
	input wire logic clk_in,
	output logic valid_out,
	output logic [7:0] byte_out,
	output var opdec_pkg::exec_ctx_t ctx_out
);
	// ****************
	// Byte feed
	// ****************
	initial begin
		valid_out = 1'b0;
		byte_out = 8'h00;
		ctx_out = 6'h00;
	end
	task automatic put(input logic [7:0] b, input logic [5:0] c);
		@(negedge clk_in);
		valid_out = 1'b1;
		byte_out = b;
		ctx_out = c;
	endtask
	// Idle bus drops valid and inverts the byte every idle cycle so a stale byte never looks fresh
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clk_in);
			valid_out = 1'b0;
			byte_out = ~byte_out;
		end
	endtask
endmodule
`default_nettype wire

// ---- dv/opcode_decode_clock_count_tb.sv ----
// Purpose: Self-checking bench for the opcode decoder
// Assumes: Results come back in the order their forms were sent
// Notes: Unhandled results compare only flags and id
`timescale 1ns/100ps
`default_nettype none
module opcode_decode_clock_count_tb;
	// ****************
	// Bench
	// ****************
	logic clk_sys_in;
	logic rst_in;
	wire logic byte_valid;
	wire logic [7:0] byte_bus;
	wire opdec_pkg::exec_ctx_t ctx;
	wire opdec_pkg::decode_result_t result;
	logic [13:0] expq[$];
	logic [13:0] want;
	int err_count;
	int checks_done;
	int seed;
	logic [7:0] fop[7] = '{8'hf8, 8'hfc, 8'hfa, 8'hf5, 8'h9f, 8'h9e, 8'hf9};
	logic [4:0] fid[7] = '{5'h0d, 5'h0e, 5'h0f, 5'h11, 5'h12, 5'h13, 5'h14};
	logic [5:0] fclk[7] = '{6'h02, 6'h02, 6'h08, 6'h02, 6'h02, 6'h03, 6'h02};
	opcode_decode_clock_count dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.byte_valid_in(byte_valid), .byte_in(byte_bus), .ctx_in(ctx), .result_out(result));
	fetch_model fm (.clk_in(clk_sys_in), .valid_out(byte_valid), .byte_out(byte_bus),
		.ctx_out(ctx));
	initial begin
		clk_sys_in = 1'b0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end
	function automatic int rnd(input int k);
		return $unsigned($random(seed)) % k;
	endfunction
	task automatic chk(input string name, input logic [13:0] seen, input logic [13:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic op(input logic [23:0] bs, input int n, input logic [5:0] c,
		input logic [13:0] e);
		expq.push_back(e);
		for (int i = 0; i < n; i++) begin
			fm.idle(rnd(2));
			fm.put(bs[8*(n-1-i) +: 8], c);
		end
	endtask
	always @(negedge clk_sys_in) begin
		if (result.valid !== 1'b0) begin
			want = expq.size() > 0 ? expq.pop_front() : 14'h0000;
			chk("decode result", want[12] ? {result[13:7], 7'h00} : result, want);
		end
	end
	initial begin
		repeat (100000) @(posedge clk_sys_in);
		chk("run time", 14'h0001, 14'h0000);
		end_sim();
	end
	initial begin
		logic [1:0] m, cp, ip, a, k;
		logic [7:0] r;
		logic [5:0] base;
		logic w, p;
		logic [23:0] bs;
		logic [13:0] e;
		logic [5:0] c;
		seed = 32'ha52a;
		err_count = 0;
		checks_done = 0;
		rst_in = 1'b1;
		repeat (12) @(posedge clk_sys_in);
		@(negedge clk_sys_in) rst_in = 1'b0;
		for (int i = 0; i < 7; i++) begin
			bs = {16'h0, fop[i]};
			c = {2'(rnd(3)), 4'(rnd(16))};
			e = {2'b10, fid[i], 1'b0, fclk[i]};
			op(bs, 1, c, e);
		end
		op(24'h000f06, 2, 6'h13, {2'b10, 5'h10, 1'b0, 6'h06});
		op(24'h000f07, 2, 6'h00, {2'b11, 12'h000});
		op(24'h000001, 1, 6'h10, {2'b11, 12'h000});
		for (int i = 0; i < 8; i++) begin
			r = {i[2:1], 6'(rnd(64))};
			w = i[0];
			op({16'h0, 5'h12, r[2:0]}, 1, 6'h20, {2'b10, 5'h02, 1'b1, 6'h03});
			e = {2'b10, 5'h01, w, r[7:6] == 2'h3 ? 6'h03 : 6'h05};
			op({8'h0, 7'h43, w, r}, 2, 6'h10, e);
			op({8'h0, 8'h8d, r}, 2, 6'(rnd(48)), {2'b10, 5'h07, 1'b0, 6'h02});
		end
		for (int i = 0; i < 6; i++) begin
			m = 2'(i % 3);
			p = m == 2'h1;
			r = 8'(rnd(256));
			op({8'h0, 8'hc5, r}, 2, {m, 4'h5}, {2'b10, 5'h08, 1'b0, p ? 6'h16 : 6'h07});
			op({8'h0, 8'hc4, r}, 2, {m, 4'h0}, {2'b10, 5'h09, 1'b0, p ? 6'h16 : 6'h07});
			op({8'h0f, 8'hb4, r}, 3, {m, 4'hc}, {2'b10, 5'h0a, 1'b0, p ? 6'h19 : 6'h07});
			op({8'h0f, 8'hb5, r}, 3, {m, 4'h3}, {2'b10, 5'h0b, 1'b0, p ? 6'h19 : 6'h07});
			op({8'h0f, 8'hb2, r}, 3, {m, 4'h6}, {2'b10, 5'h0c, 1'b0, p ? 6'h16 : 6'h07});
		end
		// Columns: real, privileged at equality, one level above, compatibility
		for (int i = 0; i < 32; i++) begin
			k = i[1:0];
			m = k == 2'h3 ? 2'h2 : {1'b0, k != 2'h0};
			a = 2'(rnd(3));
			cp = a + {1'b0, k == 2'h2};
			ip = (k == 2'h1 || k == 2'h2) ? a : 2'(rnd(4));
			w = 1'(rnd(2));
			base = 6'h06 - {4'h0, i[2], 1'b0} + {5'h00, i[3]};
			base = base + (k == 2'h0 ? 6'h06 : k == 2'h1 ? 6'h00 : 6'h14);
			e = {2'b10, 5'h03 + {3'h0, i[2], i[3]}, w, base};
			op({16'h0, 4'he, i[3], 1'b1, i[2], w}, 1, {m, cp, ip}, e);
		end
		fm.put(8'h0f, 6'h00);
		fm.idle(1);
		rst_in = 1'b1;
		fm.idle(2);
		rst_in = 1'b0;
		chk("result after reset", result, 14'h0000);
		op(24'h0000f9, 1, 6'h00, {2'b10, 5'h14, 1'b0, 6'h02});
		fm.idle(3);
		for (int i = 0; i < 20 && expq.size() > 0; i++) @(negedge clk_sys_in);
		chk("pending results", 14'(expq.size()), 14'h0000);
		end_sim();
	end
endmodule
`default_nettype wire

// ---- dv/opdec_chk.sv ----
// Purpose: Port-level checks on the opcode decoder
// Assumes: Shadow byte state follows the documented instruction forms
// Notes: Forms with a mod-reg-r/m byte are checked only when that byte follows back to back
`timescale 1ns/100ps
`default_nettype none
module opdec_chk (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_in,
	input wire opdec_pkg::exec_ctx_t ctx_in,
	input wire opdec_pkg::decode_result_t result_out
);
	// ****************
	// Shadow state
	// ****************
	logic [1:0] st_r;
	logic [1:0] st_nxt;
	wire opdec_pkg::decode_result_t r = result_out;
	wire logic [7:0] b = byte_in;
	wire logic tk0 = byte_valid_in && st_r == 2'h0;
	wire logic tk1 = byte_valid_in && st_r == 2'h1;
	wire logic two = b[7:1] == 7'h43 || b == 8'h8d || b[7:1] == 7'h62;
	wire logic prot = ctx_in.mode == opdec_pkg::MODE_PROT;
	wire logic priv = ctx_in.cur_priv <= ctx_in.io_priv;
	wire logic port = b[7:4] == 4'he && b[2];
	wire logic modreg = b[7:6] == 2'h3;
	wire logic w0 = b[0];
	// Privileged port count: out 4/5, in 6/7
	wire logic [5:0] pbase = 6'h04 + {4'h0, !b[1], 1'b0} + {5'h00, b[3]};
	assign st_nxt = !byte_valid_in ? st_r : (tk0 && b == 8'h0f) ? 2'h1 :
		((tk0 && two) || (tk1 && (b[7:1] == 7'h5a || b == 8'hb2))) ? 2'h2 : 2'h0;
	always_ff @(posedge clk_sys_in) begin
		st_r <= rst_in ? 2'h0 : st_nxt;
	end
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	sequence s_swap;
		tk0 && b[7:1] == 7'h43 ##1 byte_valid_in;
	endsequence
	sequence s_near;
		tk0 && b[7:1] == 7'h62 && prot ##1 byte_valid_in;
	endsequence
	sequence s_far;
		tk1 && b[7:1] == 7'h5a && prot ##1 byte_valid_in;
	endsequence
	a_fast_flag: assert property (
		tk0 && (b == 8'hf8 || b == 8'hfc || b == 8'hf5 || b == 8'hf9 || b == 8'h9f)
		|=> r.valid && !r.unhandled && r.clocks == 6'h02) else $error("fast flag count");
	a_slow_flag: assert property (
		tk0 && (b == 8'hfa || b == 8'h9e)
		|=> r.valid && r.clocks == ($past(b) == 8'hfa ? 6'h08 : 6'h03)) else $error("flag count");
	a_clear_ts: assert property (
		tk1 && b == 8'h06 |=> r.valid && r.clocks == 6'h06) else $error("task switch count");
	a_swap_short: assert property (
		tk0 && b[7:3] == 5'h12 |=> r.valid && r.width && r.clocks == 6'h03) else $error("short swap");
	a_swap_modrm: assert property (
		s_swap |=> r.clocks == ($past(modreg) ? 6'h03 : 6'h05) && r.width == $past(w0, 2))
		else $error("swap count or width");
	a_near_ptr: assert property (
		s_near |=> r.valid && r.clocks == 6'h16) else $error("pointer load count");
	a_far_ptr: assert property (
		s_far |=> r.valid && r.clocks == 6'h19) else $error("escaped pointer load count");
	a_port_priv: assert property (
		tk0 && port && prot && priv |=> r.clocks == $past(pbase)) else $error("port fast count");
	a_port_slow: assert property (
		tk0 && port && (ctx_in.mode == opdec_pkg::MODE_COMPAT || (prot && !priv))
		|=> r.clocks == $past(pbase) + 6'h14) else $error("port slow count");
	a_result_pulse: assert property (
		r.valid |-> $past(byte_valid_in) && (!r.unhandled || r.id == opdec_pkg::ID_NONE))
		else $error("result without byte");
endmodule
bind opcode_decode_clock_count opdec_chk u_chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
	.byte_valid_in(byte_valid_in), .byte_in(byte_in), .ctx_in(ctx_in), .result_out(result_out));
`default_nettype wire

// ---- hdl/opcode_decode_clock_count.sv ----
// Purpose: Decode a group of opcodes and report their execution clock counts
// Assumes: One opcode byte per cycle with a valid strobe; mod-reg-r/m byte follows
// Notes: Memory timing, prefixes and exceptions are handled elsewhere
`timescale 1ns/100ps
`default_nettype none

module opcode_decode_clock_count (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic byte_valid_in,
	input wire logic [7:0] byte_in,
	input wire opdec_pkg::exec_ctx_t ctx_in,
	output var opdec_pkg::decode_result_t result_out
);

	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		ST_OPCODE = 3'b001,
		ST_ESCAPED = 3'b010,
		ST_MODRM = 3'b100
	} dec_state_t;

	dec_state_t state_r, state_nxt;
	opdec_pkg::decode_result_t pend_r, pend_nxt;
	opdec_pkg::decode_result_t result_r, result_nxt;

	// Port I/O count: real, compatibility, or protected with privilege check
	function automatic logic [5:0] port_clocks(input opdec_pkg::exec_ctx_t c,
		input logic [5:0] real_clk, input logic [5:0] priv_clk,
		input logic [5:0] slow_clk);
		logic [5:0] r;
		r = real_clk;
		if (c.mode == opdec_pkg::MODE_COMPAT) begin
			r = slow_clk;
		end else if (c.mode == opdec_pkg::MODE_PROT) begin
			r = (c.cur_priv <= c.io_priv) ? priv_clk : slow_clk;
		end
		return r;
	endfunction

	// Real and compatibility modes share one column for pointer loads
	function automatic logic [5:0] mode_clocks(input opdec_pkg::exec_ctx_t c,
		input logic [5:0] real_clk, input logic [5:0] prot_clk);
		return (c.mode == opdec_pkg::MODE_PROT) ? prot_clk : real_clk;
	endfunction

	// ****************************************
	// First byte decode
	// ****************************************
	wire logic [7:0] b = byte_in;
	wire logic w_bit = b[0];
	wire logic is_escape = (b == opdec_pkg::OPC_ESCAPE);
	wire logic is_swap_rm = (b[7:1] == opdec_pkg::OPC_SWAP_RM);
	wire logic is_swap_acc = (b[7:3] == opdec_pkg::OPC_SWAP_ACC);
	wire logic is_in_fix = (b[7:1] == opdec_pkg::OPC_IN_FIXED);
	wire logic is_in_var = (b[7:1] == opdec_pkg::OPC_IN_VAR);
	wire logic is_out_fix = (b[7:1] == opdec_pkg::OPC_OUT_FIXED);
	wire logic is_out_var = (b[7:1] == opdec_pkg::OPC_OUT_VAR);
	wire logic is_load_off = (b == opdec_pkg::OPC_LOAD_OFFSET);
	wire logic is_lpds = (b == opdec_pkg::OPC_LPDS);
	wire logic is_lpes = (b == opdec_pkg::OPC_LPES);
	wire logic is_clr_carry = (b == opdec_pkg::OPC_CLR_CARRY);
	wire logic is_clr_dir = (b == opdec_pkg::OPC_CLR_DIR);
	wire logic is_clr_ie = (b == opdec_pkg::OPC_CLR_IE);
	wire logic is_inv_carry = (b == opdec_pkg::OPC_INV_CARRY);
	wire logic is_flags_to_ah = (b == opdec_pkg::OPC_FLAGS_TO_AH);
	wire logic is_ah_to_flags = (b == opdec_pkg::OPC_AH_TO_FLAGS);
	wire logic is_set_carry = (b == opdec_pkg::OPC_SET_CARRY);
	// Byte after the escape
	wire logic is_lpfs = (b == opdec_pkg::OPC_LPFS);
	wire logic is_lpgs = (b == opdec_pkg::OPC_LPGS);
	wire logic is_lpss = (b == opdec_pkg::OPC_LPSS);
	wire logic is_clr_ts = (b == opdec_pkg::OPC_CLR_TS);
	// Swap memory form depends on mod field of the following byte
	wire logic modrm_is_reg = (b[7:6] == 2'h3);

	// ****************************************
	// Clock column selection
	// ****************************************
	// Columns follow the live context; the sequencer only picks the one it keeps
	wire logic [5:0] clk_in_fix = port_clocks(ctx_in, opdec_pkg::CLK_IN_FIX_REAL,
		opdec_pkg::CLK_IN_FIX_PRIV, opdec_pkg::CLK_IN_FIX_SLOW);
	wire logic [5:0] clk_in_var = port_clocks(ctx_in, opdec_pkg::CLK_IN_VAR_REAL,
		opdec_pkg::CLK_IN_VAR_PRIV, opdec_pkg::CLK_IN_VAR_SLOW);
	wire logic [5:0] clk_out_fix = port_clocks(ctx_in, opdec_pkg::CLK_OUT_FIX_REAL,
		opdec_pkg::CLK_OUT_FIX_PRIV, opdec_pkg::CLK_OUT_FIX_SLOW);
	wire logic [5:0] clk_out_var = port_clocks(ctx_in, opdec_pkg::CLK_OUT_VAR_REAL,
		opdec_pkg::CLK_OUT_VAR_PRIV, opdec_pkg::CLK_OUT_VAR_SLOW);
	// Stack segment load shares the shorter protected figure of the unescaped loads
	wire logic [5:0] clk_ptr_near = mode_clocks(ctx_in, opdec_pkg::CLK_LP_REAL,
		opdec_pkg::CLK_LP_PROT);
	wire logic [5:0] clk_ptr_far = mode_clocks(ctx_in, opdec_pkg::CLK_LP_REAL,
		opdec_pkg::CLK_LP_PROT_EXT);
	wire logic [5:0] clk_swap_rm = modrm_is_reg ? opdec_pkg::CLK_SWAP_REG
		: opdec_pkg::CLK_SWAP_MEM;

	always_comb begin
		state_nxt = state_r;
		pend_nxt = pend_r;
		result_nxt = result_r;
		result_nxt.valid = 1'b0;
		result_nxt.unhandled = 1'b0;
		if (byte_valid_in) begin
			case (state_r)
				ST_OPCODE: begin
					pend_nxt = '0;
					pend_nxt.valid = 1'b1;
					if (is_escape) begin
						state_nxt = ST_ESCAPED;
					end else if (is_swap_rm) begin
						pend_nxt.id = opdec_pkg::ID_SWAP_RM;
						pend_nxt.width = w_bit;
						state_nxt = ST_MODRM;
					end else if (is_load_off) begin
						pend_nxt.id = opdec_pkg::ID_LOAD_OFFSET;
						pend_nxt.clocks = opdec_pkg::CLK_LOAD_OFFSET;
						state_nxt = ST_MODRM;
					end else if (is_lpds) begin
						pend_nxt.id = opdec_pkg::ID_LPDS;
						pend_nxt.clocks = clk_ptr_near;
						state_nxt = ST_MODRM;
					end else if (is_lpes) begin
						pend_nxt.id = opdec_pkg::ID_LPES;
						pend_nxt.clocks = clk_ptr_near;
						state_nxt = ST_MODRM;
					end else begin
						// Single-byte forms complete at once
						result_nxt = '0;
						result_nxt.valid = 1'b1;
						if (is_swap_acc) begin
							result_nxt.id = opdec_pkg::ID_SWAP_ACC;
							result_nxt.width = 1'b1;
							result_nxt.clocks = opdec_pkg::CLK_SWAP_REG;
						end else if (is_in_fix) begin
							result_nxt.id = opdec_pkg::ID_IN_FIXED;
							result_nxt.width = w_bit;
							result_nxt.clocks = clk_in_fix;
						end else if (is_in_var) begin
							result_nxt.id = opdec_pkg::ID_IN_VAR;
							result_nxt.width = w_bit;
							result_nxt.clocks = clk_in_var;
						end else if (is_out_fix) begin
							result_nxt.id = opdec_pkg::ID_OUT_FIXED;
							result_nxt.width = w_bit;
							result_nxt.clocks = clk_out_fix;
						end else if (is_out_var) begin
							result_nxt.id = opdec_pkg::ID_OUT_VAR;
							result_nxt.width = w_bit;
							result_nxt.clocks = clk_out_var;
						end else if (is_clr_carry) begin
							result_nxt.id = opdec_pkg::ID_CLR_CARRY;
							result_nxt.clocks = opdec_pkg::CLK_FLAG_FAST;
						end else if (is_clr_dir) begin
							result_nxt.id = opdec_pkg::ID_CLR_DIR;
							result_nxt.clocks = opdec_pkg::CLK_FLAG_FAST;
						end else if (is_clr_ie) begin
							result_nxt.id = opdec_pkg::ID_CLR_IE;
							result_nxt.clocks = opdec_pkg::CLK_CLR_IE;
						end else if (is_inv_carry) begin
							result_nxt.id = opdec_pkg::ID_INV_CARRY;
							result_nxt.clocks = opdec_pkg::CLK_FLAG_FAST;
						end else if (is_flags_to_ah) begin
							result_nxt.id = opdec_pkg::ID_FLAGS_TO_AH;
							result_nxt.clocks = opdec_pkg::CLK_FLAG_FAST;
						end else if (is_ah_to_flags) begin
							result_nxt.id = opdec_pkg::ID_AH_TO_FLAGS;
							result_nxt.clocks = opdec_pkg::CLK_AH_TO_FLAGS;
						end else if (is_set_carry) begin
							result_nxt.id = opdec_pkg::ID_SET_CARRY;
							result_nxt.clocks = opdec_pkg::CLK_FLAG_FAST;
						end else begin
							result_nxt.unhandled = 1'b1;
						end
					end
				end
				ST_ESCAPED: begin
					state_nxt = ST_MODRM;
					if (is_lpfs) begin
						pend_nxt.id = opdec_pkg::ID_LPFS;
						pend_nxt.clocks = clk_ptr_far;
					end else if (is_lpgs) begin
						pend_nxt.id = opdec_pkg::ID_LPGS;
						pend_nxt.clocks = clk_ptr_far;
					end else if (is_lpss) begin
						pend_nxt.id = opdec_pkg::ID_LPSS;
						pend_nxt.clocks = clk_ptr_near;
					end else begin
						// No mod-reg-r/m follows: report now
						state_nxt = ST_OPCODE;
						result_nxt = '0;
						result_nxt.valid = 1'b1;
						if (is_clr_ts) begin
							result_nxt.id = opdec_pkg::ID_CLR_TS;
							result_nxt.clocks = opdec_pkg::CLK_CLR_TS;
						end else begin
							result_nxt.unhandled = 1'b1;
						end
					end
				end
				ST_MODRM: begin
					state_nxt = ST_OPCODE;
					result_nxt = pend_r;
					if (pend_r.id == opdec_pkg::ID_SWAP_RM) begin
						result_nxt.clocks = clk_swap_rm;
					end
				end
				default: begin
					state_nxt = ST_OPCODE;
				end
			endcase
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_r <= ST_OPCODE;
			pend_r <= '0;
			result_r <= '0;
		end else begin
			state_r <= state_nxt;
			pend_r <= pend_nxt;
			result_r <= result_nxt;
		end
	end

	assign result_out = result_r;

endmodule

`default_nettype wire

// ---- shared/opdec_pkg.sv ----
// Purpose: Shared types and constants for the opcode decoder with clock counts
// Assumes: Opcode bytes arrive one at a time from the fetch stage
// Notes: Clock counts are execution clocks per instruction form
package opdec_pkg;

	// ****************************************
	// Opcode patterns
	// ****************************************
	localparam logic [7:0] OPC_ESCAPE = 8'h0f;
	localparam logic [6:0] OPC_SWAP_RM = 7'h43;
	localparam logic [4:0] OPC_SWAP_ACC = 5'h12;
	localparam logic [6:0] OPC_IN_FIXED = 7'h72;
	localparam logic [6:0] OPC_IN_VAR = 7'h76;
	localparam logic [6:0] OPC_OUT_FIXED = 7'h73;
	localparam logic [6:0] OPC_OUT_VAR = 7'h77;
	localparam logic [7:0] OPC_LOAD_OFFSET = 8'h8d;
	localparam logic [7:0] OPC_LPDS = 8'hc5;
	localparam logic [7:0] OPC_LPES = 8'hc4;
	localparam logic [7:0] OPC_LPFS = 8'hb4;
	localparam logic [7:0] OPC_LPGS = 8'hb5;
	localparam logic [7:0] OPC_LPSS = 8'hb2;
	localparam logic [7:0] OPC_CLR_CARRY = 8'hf8;
	localparam logic [7:0] OPC_CLR_DIR = 8'hfc;
	localparam logic [7:0] OPC_CLR_IE = 8'hfa;
	localparam logic [7:0] OPC_CLR_TS = 8'h06;
	localparam logic [7:0] OPC_INV_CARRY = 8'hf5;
	localparam logic [7:0] OPC_FLAGS_TO_AH = 8'h9f;
	localparam logic [7:0] OPC_AH_TO_FLAGS = 8'h9e;
	localparam logic [7:0] OPC_SET_CARRY = 8'hf9;

	// ****************************************
	// Clock counts
	// ****************************************
	localparam logic [5:0] CLK_SWAP_REG = 6'h03;
	localparam logic [5:0] CLK_SWAP_MEM = 6'h05;
	localparam logic [5:0] CLK_IN_FIX_REAL = 6'h0c;
	localparam logic [5:0] CLK_IN_FIX_PRIV = 6'h06;
	localparam logic [5:0] CLK_IN_FIX_SLOW = 6'h1a;
	localparam logic [5:0] CLK_IN_VAR_REAL = 6'h0d;
	localparam logic [5:0] CLK_IN_VAR_PRIV = 6'h07;
	localparam logic [5:0] CLK_IN_VAR_SLOW = 6'h1b;
	localparam logic [5:0] CLK_OUT_FIX_REAL = 6'h0a;
	localparam logic [5:0] CLK_OUT_FIX_PRIV = 6'h04;
	localparam logic [5:0] CLK_OUT_FIX_SLOW = 6'h18;
	localparam logic [5:0] CLK_OUT_VAR_REAL = 6'h0b;
	localparam logic [5:0] CLK_OUT_VAR_PRIV = 6'h05;
	localparam logic [5:0] CLK_OUT_VAR_SLOW = 6'h19;
	localparam logic [5:0] CLK_LOAD_OFFSET = 6'h02;
	localparam logic [5:0] CLK_LP_REAL = 6'h07;
	localparam logic [5:0] CLK_LP_PROT = 6'h16;
	localparam logic [5:0] CLK_LP_PROT_EXT = 6'h19;
	localparam logic [5:0] CLK_FLAG_FAST = 6'h02;
	localparam logic [5:0] CLK_CLR_IE = 6'h08;
	localparam logic [5:0] CLK_CLR_TS = 6'h06;
	localparam logic [5:0] CLK_AH_TO_FLAGS = 6'h03;
	localparam logic [5:0] CLK_RESET = 6'h00;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		MODE_REAL = 2'h0,
		MODE_PROT = 2'h1,
		MODE_COMPAT = 2'h2
	} cpu_mode_t;

	typedef enum logic [4:0] {
		ID_NONE = 5'h00,
		ID_SWAP_RM = 5'h01,
		ID_SWAP_ACC = 5'h02,
		ID_IN_FIXED = 5'h03,
		ID_IN_VAR = 5'h04,
		ID_OUT_FIXED = 5'h05,
		ID_OUT_VAR = 5'h06,
		ID_LOAD_OFFSET = 5'h07,
		ID_LPDS = 5'h08,
		ID_LPES = 5'h09,
		ID_LPFS = 5'h0a,
		ID_LPGS = 5'h0b,
		ID_LPSS = 5'h0c,
		ID_CLR_CARRY = 5'h0d,
		ID_CLR_DIR = 5'h0e,
		ID_CLR_IE = 5'h0f,
		ID_CLR_TS = 5'h10,
		ID_INV_CARRY = 5'h11,
		ID_FLAGS_TO_AH = 5'h12,
		ID_AH_TO_FLAGS = 5'h13,
		ID_SET_CARRY = 5'h14
	} instr_id_t;

	// Context that selects among the clock columns
	typedef struct packed {
		cpu_mode_t mode;
		logic [1:0] cur_priv;
		logic [1:0] io_priv;
	} exec_ctx_t;

	// Result handed to the execution stage
	typedef struct packed {
		logic valid;
		logic unhandled;
		instr_id_t id;
		logic width;
		logic [5:0] clocks;
	} decode_result_t;

endpackage
